//--- hdl/rcr_ctrl.sv
// Contract
// - writes into the protected eeprom region are dropped, data unchanged
// - codes 000..011 protect none, 180-1FF, 100-1FF, whole array
// - codes 100..111 protect 000-03F, 000-07F, 000-0FF, whole array
// - alarm interrupt output only with an alarm enabled and frequency select zero
// - repeat mode pulses output on every enabled alarm match, indefinitely
// - either enabled alarm asserts output; repeat mode pulses per alarm
// - frequency select: alarm, 32.768kHz, 4096Hz, 1Hz on shared pin
// - nonzero frequency select suppresses alarm signalling on the pin; status flags still set
// - six-bit cap code sets both crystal capacitor banks
// - digital trim changes oscillator counts per second
// - top digital trim bit is sign; zero magnitude means no correction
// - magnitude bits weigh 10ppm and 20ppm
// - control settings held non-volatile across supply loss
// - bus-disable bit ignores serial bus writes while on backup supply; reads are still answered
// - switch-mode bit selects standard or legacy supply criterion
// - alarm flags set regardless of enables, cleared by status read
module rcr_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // oscillator tick, asynchronous
    input wire logic osc_i,
    // byte access from the serial protocol engine, same clock
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic sr_read_done_i,
    // eeprom write request from protocol engine
    input wire logic ee_wr_i,
    input wire logic [8:0] ee_addr_i,
    // alarm matches and supply state
    input wire logic alarm0_match_i,
    input wire logic alarm1_match_i,
    input wire logic on_backup_i,
    // non-volatile image loaded at power-up
    input wire logic nv_load_i,
    input wire logic [39:0] nv_image_i,
    // outputs
    output logic [7:0] rdata_o,
    output logic ee_wr_ok_o,
    output logic irq_freq_out_pin_n_o,
    output logic [5:0] cap_code_x1_o,
    output logic [5:0] cap_code_x2_o,
    output logic [1:0] count_adj_o,
    output logic bus_enable_o,
    output logic supply_switch_mode_o,
    output logic nv_store_o,
    output logic [39:0] nv_image_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] wp;
        logic [7:0] irq;
        logic [7:0] cap;
        logic [7:0] cnt;
        logic [7:0] power_switch_ctrl;
        logic write_latch;
        logic reg_write_latch;
        logic alarm0_flag;
        logic alarm1_flag;
        logic [2:0] osc_sync;
        logic osc_level;
        logic osc_tick;
        logic [15:0] osc_cnt;
        logic [1:0] corr_sec;
        logic [1:0] count_adj;
        logic f4k;
        logic f1;
        logic [3:0] pulse_cnt;
        logic [1:0] pulse_queue;
        logic pin_n;
        logic [7:0] rdata;
        logic ee_ok;
        logic nv_store;
        logic bus_en;
    } rcr_state_t;

    rcr_state_t st;
    rcr_state_t next_st;

    logic in_protect;
    logic [2:0] psel;
    logic ctrl_addr;

    // ----------------------------------------
    // protect decode
    // ----------------------------------------
    always_comb begin
        psel = st.wp[rcr_pkg::POS_PROTECT_SEL +: 3];
        case (psel)
            3'h0: in_protect = 1'b0;
            3'h1: in_protect = ee_addr_i >= rcr_pkg::EE_QUARTER;
            3'h2: in_protect = ee_addr_i >= rcr_pkg::EE_HALF;
            3'h4: in_protect = ee_addr_i <= rcr_pkg::EE_PG4_END;
            3'h5: in_protect = ee_addr_i <= rcr_pkg::EE_PG8_END;
            3'h6: in_protect = ee_addr_i <= rcr_pkg::EE_PG16_END;
            default: in_protect = ee_addr_i <= rcr_pkg::EE_TOP;
        endcase
        ctrl_addr = addr_i >= rcr_pkg::ADDR_WRITE_PROTECT && addr_i <= rcr_pkg::ADDR_POWER_SWITCH;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic fire0;
        logic fire1;
        logic alarm_mode;
        logic repeat_mode;
        logic sec_tick;
        logic [1:0] mag;
        fire0 = 1'b0;
        fire1 = 1'b0;
        alarm_mode = 1'b0;
        repeat_mode = 1'b0;
        sec_tick = 1'b0;
        mag = 2'h0;
        next_st = st;
        next_st.ee_ok = 1'b0;
        next_st.nv_store = 1'b0;

        // oscillator: three stages, edge once second and third agree
        next_st.osc_sync = {st.osc_sync[1:0], osc_i};
        next_st.osc_tick = 1'b0;
        if (st.osc_sync[2] == st.osc_sync[1] && st.osc_sync[2] != st.osc_level) begin
            next_st.osc_level = st.osc_sync[2];
            next_st.osc_tick = st.osc_sync[2];
        end

        // digital trim: sign and 10/20ppm magnitude; zero magnitude gives none
        mag = {st.cnt[rcr_pkg::POS_CORR_20], st.cnt[rcr_pkg::POS_CORR_10]};
        if (st.osc_tick) begin
            next_st.osc_cnt = st.osc_cnt + 16'h0001;
            // 4096Hz is the oscillator divided by eight: toggle every fourth tick
            if (st.osc_cnt[1:0] == 2'(rcr_pkg::F4096_DIV / 2 - 1)) begin
                next_st.f4k = ~st.f4k;
            end
            if (st.osc_cnt == 16'(rcr_pkg::SEC_COUNTS / 2 - 1) ||
                st.osc_cnt == 16'(rcr_pkg::SEC_COUNTS - 1)) begin
                next_st.f1 = ~st.f1;
            end
            if (st.osc_cnt == 16'(rcr_pkg::SEC_COUNTS - 1)) begin
                sec_tick = 1'b1;
                next_st.osc_cnt = 16'h0000;
            end
        end
        next_st.count_adj = 2'h0;
        if (sec_tick) begin
            // spreads ppm over seconds: one count per three seconds at each 10ppm step weight
            next_st.corr_sec = (st.corr_sec == 2'(rcr_pkg::CORR_PERIOD_S - 1)) ? 2'h0 : st.corr_sec + 2'h1;
            if (mag != 2'h0 && st.corr_sec < mag) begin
                next_st.count_adj = st.cnt[rcr_pkg::POS_CORR_SIGN] ? 2'h2 : 2'h1;
            end
        end

        // alarm flags: set wins over clear
        if (sr_read_done_i) begin
            next_st.alarm0_flag = 1'b0;
            next_st.alarm1_flag = 1'b0;
        end
        if (alarm0_match_i) begin
            next_st.alarm0_flag = 1'b1;
        end
        if (alarm1_match_i) begin
            next_st.alarm1_flag = 1'b1;
        end

        // shared pin
        alarm_mode = st.irq[rcr_pkg::POS_FREQ_SEL +: 2] == 2'h0;
        repeat_mode = st.irq[rcr_pkg::POS_REPEAT];
        fire0 = alarm0_match_i && st.irq[rcr_pkg::POS_AL0_ON];
        fire1 = alarm1_match_i && st.irq[rcr_pkg::POS_AL1_ON];
        case (rcr_pkg::rcr_freq_t'(st.irq[rcr_pkg::POS_FREQ_SEL +: 2]))
            rcr_pkg::RCR_FREQ_32K: next_st.pin_n = st.osc_sync[2];
            rcr_pkg::RCR_FREQ_4K: next_st.pin_n = st.f4k;
            rcr_pkg::RCR_FREQ_1HZ: next_st.pin_n = st.f1;
            default: next_st.pin_n = 1'b1;
        endcase
        if (!alarm_mode || !(st.irq[rcr_pkg::POS_AL0_ON] || st.irq[rcr_pkg::POS_AL1_ON])) begin
            next_st.pulse_cnt = 4'h0;
            next_st.pulse_queue = 2'h0;
        end else if (repeat_mode) begin
            // separate pulse per alarm match; a second match waits in the queue
            next_st.pulse_queue = st.pulse_queue + 2'(fire0) + 2'(fire1);
            if (st.pulse_cnt != 4'h0) begin
                if (st.osc_tick) begin
                    next_st.pulse_cnt = st.pulse_cnt - 4'h1;
                end
                next_st.pin_n = 1'b0;
                if (st.pulse_cnt == 4'h1 && st.osc_tick) begin
                    next_st.pin_n = 1'b1;
                end
            end else if (st.pulse_queue != 2'h0 && st.pin_n) begin
                next_st.pulse_cnt = 4'(rcr_pkg::PULSE_OSC_TICKS);
                next_st.pulse_queue = st.pulse_queue - 2'h1 + 2'(fire0) + 2'(fire1);
                next_st.pin_n = 1'b0;
            end
        end else begin
            // single event: low while an enabled alarm's flag stays set
            next_st.pin_n = !((st.alarm0_flag && st.irq[rcr_pkg::POS_AL0_ON]) ||
                (st.alarm1_flag && st.irq[rcr_pkg::POS_AL1_ON]));
        end

        // supply related controls
        next_st.bus_en = !(on_backup_i && st.power_switch_ctrl[rcr_pkg::POS_BUS_OFF]);

        // register writes, gated by the host's two-step arming
        if (wr_i && st.bus_en) begin
            if (addr_i == rcr_pkg::ADDR_STATUS) begin
                if (wdata_i == rcr_pkg::ARM_WRITE) begin
                    next_st.write_latch = 1'b1;
                end else if (wdata_i == rcr_pkg::ARM_REG_WRITE && st.write_latch) begin
                    next_st.reg_write_latch = 1'b1;
                end else if (wdata_i == 8'h00) begin
                    next_st.write_latch = 1'b0;
                    next_st.reg_write_latch = 1'b0;
                end
            end else if (ctrl_addr && st.reg_write_latch) begin
                case (addr_i)
                    rcr_pkg::ADDR_WRITE_PROTECT: next_st.wp = {wdata_i[7:3], 3'h0};
                    rcr_pkg::ADDR_ALARM_IRQ_FREQ: next_st.irq = {wdata_i[7:3], 3'h0};
                    rcr_pkg::ADDR_CAP_TUNE: next_st.cap = {2'h0, wdata_i[5:0]};
                    rcr_pkg::ADDR_COUNT_TUNE: next_st.cnt = {5'h00, wdata_i[2:0]};
                    default: next_st.power_switch_ctrl = wdata_i;
                endcase
                next_st.nv_store = 1'b1;
                next_st.reg_write_latch = 1'b0;
            end
        end
        if (ee_wr_i && st.bus_en && !in_protect) begin
            next_st.ee_ok = 1'b1;
        end

        // readback
        if (rd_i) begin
            case (addr_i)
                rcr_pkg::ADDR_WRITE_PROTECT: next_st.rdata = st.wp;
                rcr_pkg::ADDR_ALARM_IRQ_FREQ: next_st.rdata = st.irq;
                rcr_pkg::ADDR_CAP_TUNE: next_st.rdata = st.cap;
                rcr_pkg::ADDR_COUNT_TUNE: next_st.rdata = st.cnt;
                rcr_pkg::ADDR_POWER_SWITCH: next_st.rdata = st.power_switch_ctrl;
                rcr_pkg::ADDR_STATUS: next_st.rdata = {1'b0, st.alarm1_flag, st.alarm0_flag, 2'h0,
                    st.reg_write_latch, st.write_latch, 1'b0};
                default: next_st.rdata = 8'h00;
            endcase
        end

        // power-up reload of the stored settings
        if (nv_load_i) begin
            next_st.wp = nv_image_i[7:0];
            next_st.irq = nv_image_i[15:8];
            next_st.cap = nv_image_i[23:16];
            next_st.cnt = nv_image_i[31:24];
            next_st.power_switch_ctrl = nv_image_i[39:32];
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.wp <= rcr_pkg::RST_WRITE_PROTECT;
            st.irq <= rcr_pkg::RST_ALARM_IRQ_FREQ;
            st.cap <= rcr_pkg::RST_CAP_TUNE;
            st.cnt <= rcr_pkg::RST_COUNT_TUNE;
            st.power_switch_ctrl <= rcr_pkg::RST_POWER_SWITCH;
            st.pin_n <= 1'b1;
            st.bus_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        rdata_o = st.rdata;
        ee_wr_ok_o = st.ee_ok;
        irq_freq_out_pin_n_o = st.pin_n;
        cap_code_x1_o = st.cap[5:0];
        cap_code_x2_o = st.cap[5:0];
        count_adj_o = st.count_adj;
        bus_enable_o = st.bus_en;
        supply_switch_mode_o = st.power_switch_ctrl[rcr_pkg::POS_SW_MODE];
        nv_store_o = st.nv_store;
        nv_image_o = {st.power_switch_ctrl, st.cnt, st.cap, st.irq, st.wp};
    end
endmodule

//--- hdl/rcr_pkg.sv
package rcr_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [8:0] ADDR_WRITE_PROTECT = 9'h010;
    localparam logic [8:0] ADDR_ALARM_IRQ_FREQ = 9'h011;
    localparam logic [8:0] ADDR_CAP_TUNE = 9'h012;
    localparam logic [8:0] ADDR_COUNT_TUNE = 9'h013;
    localparam logic [8:0] ADDR_POWER_SWITCH = 9'h014;
    localparam logic [8:0] ADDR_STATUS = 9'h03F;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_WRITE_PROTECT = 8'h18;
    localparam logic [7:0] RST_ALARM_IRQ_FREQ = 8'h00;
    localparam logic [7:0] RST_CAP_TUNE = 8'h00;
    localparam logic [7:0] RST_COUNT_TUNE = 8'h00;
    localparam logic [7:0] RST_POWER_SWITCH = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int POS_PROTECT_SEL = 5;
    localparam int POS_REPEAT = 7;
    localparam int POS_AL1_ON = 6;
    localparam int POS_AL0_ON = 5;
    localparam int POS_FREQ_SEL = 3;
    localparam int POS_CORR_SIGN = 2;
    localparam int POS_CORR_10 = 1;
    localparam int POS_CORR_20 = 0;
    localparam int POS_BUS_OFF = 7;
    localparam int POS_SW_MODE = 6;
    localparam int POS_SR_AL1 = 6;
    localparam int POS_SR_AL0 = 5;
    localparam int POS_SR_REG_WRITE_LATCH = 2;
    localparam int POS_SR_WEL = 1;

    // ----------------------------------------
    // latch arming codes
    // ----------------------------------------
    localparam logic [7:0] ARM_WRITE = 8'h02;
    localparam logic [7:0] ARM_REG_WRITE = 8'h06;

    // ----------------------------------------
    // protected region bounds
    // ----------------------------------------
    localparam logic [8:0] EE_TOP = 9'h1FF;
    localparam logic [8:0] EE_QUARTER = 9'h180;
    localparam logic [8:0] EE_HALF = 9'h100;
    localparam logic [8:0] EE_PG4_END = 9'h03F;
    localparam logic [8:0] EE_PG8_END = 9'h07F;
    localparam logic [8:0] EE_PG16_END = 9'h0FF;

    // ----------------------------------------
    // timing: oscillator ticks (one-cycle enables)
    // ----------------------------------------
    localparam int CLK_HZ = 200000000;
    localparam int OSC_HZ = 32768;
    localparam int F4096_DIV = OSC_HZ / 4096;
    localparam int F1_DIV = OSC_HZ;
    localparam int PULSE_OSC_TICKS = 8;
    // one second holds this many oscillator counts, nominally
    localparam int SEC_COUNTS = OSC_HZ;
    // 10 ppm of 32768 counts, applied once per this many seconds
    localparam int CORR_PERIOD_S = 3;
    localparam int CORR_STEP_COUNTS = 1;

    typedef enum logic [1:0] {
        RCR_FREQ_ALARM,
        RCR_FREQ_32K,
        RCR_FREQ_4K,
        RCR_FREQ_1HZ
    } rcr_freq_t;
endpackage

//--- verif/rcr_ctrl_sva.sv
module rcr_ctrl_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // inputs
    input wire logic ee_wr_i,
    input wire logic [8:0] ee_addr_i,
    input wire logic alarm0_match_i,
    input wire logic alarm1_match_i,
    input wire logic on_backup_i,
    // outputs
    input wire logic ee_wr_ok_o,
    input wire logic irq_freq_out_pin_n_o,
    input wire logic [5:0] cap_code_x1_o,
    input wire logic [5:0] cap_code_x2_o,
    input wire logic [1:0] count_adj_o,
    input wire logic bus_enable_o,
    input wire logic supply_switch_mode_o,
    input wire logic [39:0] nv_image_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [2:0] bp;
    logic prot;
    logic fz;
    assign bp = nv_image_o[7:5];
    assign fz = nv_image_o[12:11] == 2'h0;
    always_comb begin
        case (bp)
            3'h0: prot = 1'b0;
            3'h1: prot = ee_addr_i >= 9'h180;
            3'h2: prot = ee_addr_i >= 9'h100;
            3'h4: prot = ee_addr_i <= 9'h03F;
            3'h5: prot = ee_addr_i <= 9'h07F;
            3'h6: prot = ee_addr_i <= 9'h0FF;
            default: prot = 1'b1;
        endcase
    end
    // ------
    // assertions
    // ------
    a_protect_drop: assert property (ee_wr_i && prot |=> !ee_wr_ok_o)
        else $error("protected write accepted");
    a_low_pass: assert property (ee_wr_i && !prot && !bp[2] && bus_enable_o |=> ee_wr_ok_o)
        else $error("open write dropped");
    a_high_pass: assert property (ee_wr_i && !prot && bp[2] && bus_enable_o |=> ee_wr_ok_o)
        else $error("open write dropped");
    a_irq_gate: assert property ((nv_image_o[14:11] == 4'h0) [*3] |-> irq_freq_out_pin_n_o)
        else $error("pin low with alarms off");
    a_alarm0_pin: assert property (alarm0_match_i && nv_image_o[13] && fz |-> ##[1:4] !irq_freq_out_pin_n_o)
        else $error("alarm0 not signalled");
    a_alarm1_pin: assert property (alarm1_match_i && nv_image_o[14] && fz |-> ##[1:4] !irq_freq_out_pin_n_o)
        else $error("alarm1 not signalled");
    a_cap_banks: assert property ($stable(nv_image_o[21:16]) [*2] |->
        cap_code_x1_o == nv_image_o[21:16] && cap_code_x2_o == nv_image_o[21:16])
        else $error("cap code mismatch");
    a_corr_dir: assert property (count_adj_o != 2'h0 |-> count_adj_o == (nv_image_o[26] ? 2'h2 : 2'h1))
        else $error("correction direction");
    a_corr_idle: assert property ((nv_image_o[25:24] == 2'h0) [*2] |-> count_adj_o == 2'h0)
        else $error("correction at zero");
    a_bus_gate: assert property (($stable(on_backup_i) && $stable(nv_image_o[39])) [*2] |->
        bus_enable_o == !(on_backup_i && nv_image_o[39]))
        else $error("bus enable wrong");
    a_switch_mode: assert property ($stable(nv_image_o[38]) [*2] |-> supply_switch_mode_o == nv_image_o[38])
        else $error("switch mode wrong");
    c_prot: cover property (ee_wr_i && prot);
    c_pin: cover property ($fell(irq_freq_out_pin_n_o));
    c_bus_off: cover property (!bus_enable_o);
endmodule

//--- verif/rcr_host.sv
module rcr_host (
    // clock
    input wire logic clk_i,
    // byte access toward the block
    output logic wr_o,
    output logic rd_o,
    output logic [8:0] addr_o,
    output logic [7:0] wdata_o,
    output logic sr_done_o,
    output logic ee_wr_o,
    output logic [8:0] ee_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {wr_o, rd_o, sr_done_o, ee_wr_o} = 4'h0;
        addr_o = 9'h000;
        wdata_o = 8'h00;
        ee_addr_o = 9'h000;
    end
    // released lines show the inverse, never the last value
    task automatic put(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
    endtask
    task automatic put_ctrl(input logic [8:0] a, input logic [7:0] d);
        put(rcr_pkg::ADDR_STATUS, rcr_pkg::ARM_WRITE);
        put(rcr_pkg::ADDR_STATUS, rcr_pkg::ARM_REG_WRITE);
        put(a, d);
    endtask
    task automatic get(input logic [8:0] a);
        @(negedge clk_i);
        {addr_o, rd_o} = {a, 1'b1};
        @(negedge clk_i);
        {addr_o, rd_o} = {~a, 1'b0};
        // eighth bit clock of a status read comes after the byte
        if (a == rcr_pkg::ADDR_STATUS) begin
            sr_done_o = 1'b1;
            @(negedge clk_i);
            sr_done_o = 1'b0;
        end
    endtask
    task automatic ee(input logic [8:0] a);
        @(negedge clk_i);
        {ee_addr_o, ee_wr_o} = {a, 1'b1};
        @(negedge clk_i);
        {ee_addr_o, ee_wr_o} = {~a, 1'b0};
    endtask
endmodule

//--- verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, sys_rst_i, osc_i, wr_i, rd_i, sr_read_done_i, ee_wr_i, on_backup_i, nv_load_i;
    logic alarm0_match_i, alarm1_match_i, ee_wr_ok_o, irq_freq_out_pin_n_o, bus_enable_o;
    logic supply_switch_mode_o, nv_store_o, rd_d, ee_d;
    logic [8:0] addr_i, ee_addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [39:0] nv_image_i, nv_image_o;
    logic [5:0] cap_code_x1_o, cap_code_x2_o;
    logic [1:0] count_adj_o;
    logic [15:0] e;
    logic [15:0] exp_q[$];
    logic ok_q[$];
    logic [7:0] v[5], msk[5], rv[5];
    logic [8:0] pts[10];
    int n_errors, tests_run, i, j, n;
    rcr_ctrl uut (.*);
    rcr_host host (.clk_i(clk_i), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i),
        .sr_done_o(sr_read_done_i), .ee_wr_o(ee_wr_i), .ee_addr_o(ee_addr_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // oscillator sped up so pulses and the 4096Hz output fit the run
    initial begin
        osc_i = 1'b0;
        forever #20 osc_i = ~osc_i;
    end
    // ------
    // checking
    // ------
    task automatic cmp_byte(input logic [7:0] ex, input logic [7:0] got);
        tests_run++;
        if (got !== ex) begin
            n_errors++;
            $display("Error at %0t: expected %h got %h", $time, ex, got);
        end
    endtask
    task automatic cmp_bit(input logic ex, input logic got);
        cmp_byte({7'h00, ex}, {7'h00, got});
    endtask
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        rd_d <= rd_i;
        ee_d <= ee_wr_i;
    end
    always @(negedge clk_i) begin
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            cmp_byte(e[7:0], rdata_o & e[15:8]);
        end
        if (ee_d === 1'b1) cmp_bit(ok_q.pop_front(), ee_wr_ok_o);
    end
    // ------
    // stimulus helpers
    // ------
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] m, input logic [7:0] x);
        exp_q.push_back({m, x & m});
        host.get(a);
    endtask
    task automatic ee_chk(input logic [8:0] a, input logic ok);
        ok_q.push_back(ok);
        host.ee(a);
    endtask
    task automatic fire(input logic [1:0] m);
        @(negedge clk_i);
        {alarm1_match_i, alarm0_match_i} = m;
        @(negedge clk_i);
        {alarm1_match_i, alarm0_match_i} = 2'h0;
    endtask
    task automatic wait_pin(input logic lvl);
        int k;
        for (k = 0; k < 300 && irq_freq_out_pin_n_o !== lvl; k++) @(negedge clk_i);
        if (k == 300) begin
            n_errors++;
            finish_test();
        end
        cmp_bit(lvl, irq_freq_out_pin_n_o);
    endtask
    // skips the settling after a mode change, then counts whole periods
    task automatic falls(output int cnt);
        logic p;
        cnt = 0;
        repeat (16) @(negedge clk_i);
        p = irq_freq_out_pin_n_o;
        repeat (640) begin
            @(negedge clk_i);
            if (p === 1'b1 && irq_freq_out_pin_n_o === 1'b0) cnt++;
            p = irq_freq_out_pin_n_o;
        end
    endtask
    function automatic logic hit(input logic [2:0] c, input logic [8:0] a);
        case (c)
            3'h0: return 1'b0;
            3'h1: return a >= rcr_pkg::EE_QUARTER;
            3'h2: return a >= rcr_pkg::EE_HALF;
            3'h4: return a <= rcr_pkg::EE_PG4_END;
            3'h5: return a <= rcr_pkg::EE_PG8_END;
            3'h6: return a <= rcr_pkg::EE_PG16_END;
            default: return 1'b1;
        endcase
    endfunction
    initial begin
        {sys_rst_i, alarm0_match_i, alarm1_match_i, on_backup_i, nv_load_i} = 5'h10;
        nv_image_i = 40'h0;
        n_errors = 0;
        tests_run = 0;
        msk = '{8'hF8, 8'hF8, 8'h3F, 8'h07, 8'hC0};
        rv = '{rcr_pkg::RST_WRITE_PROTECT, rcr_pkg::RST_ALARM_IRQ_FREQ, rcr_pkg::RST_CAP_TUNE,
            rcr_pkg::RST_COUNT_TUNE, rcr_pkg::RST_POWER_SWITCH};
        pts = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h17F, 9'h180, 9'h1FF};
        n = $urandom(29597);
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (i = 0; i < 5; i++) begin
            v[i] = 8'($urandom) & msk[i];
            host.put(9'h010 + 9'(i), ~v[i]);
            rd_chk(9'h010 + 9'(i), 8'hFF, rv[i]);
            host.put_ctrl(9'h010 + 9'(i), v[i]);
            rd_chk(9'h010 + 9'(i), msk[i], v[i]);
        end
        sys_rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        {sys_rst_i, nv_load_i} = 2'b01;
        nv_image_i = {v[4], v[3], v[2], v[1], v[0]};
        @(negedge clk_i);
        nv_load_i = 1'b0;
        nv_image_i = ~nv_image_i;
        for (i = 0; i < 5; i++) rd_chk(9'h010 + 9'(i), msk[i], v[i]);
        for (i = 0; i < 8; i++) begin
            host.put_ctrl(rcr_pkg::ADDR_WRITE_PROTECT, {3'(i), 5'h18});
            for (j = 0; j < 10; j++) ee_chk(pts[j], !hit(3'(i), pts[j]));
        end
        host.put_ctrl(rcr_pkg::ADDR_ALARM_IRQ_FREQ, 8'h20);
        fire(2'b10);
        repeat (4) @(negedge clk_i);
        cmp_bit(1'b1, irq_freq_out_pin_n_o);
        fire(2'b01);
        wait_pin(1'b0);
        rd_chk(rcr_pkg::ADDR_STATUS, 8'h60, 8'h60);
        wait_pin(1'b1);
        rd_chk(rcr_pkg::ADDR_STATUS, 8'h60, 8'h00);
        host.put_ctrl(rcr_pkg::ADDR_ALARM_IRQ_FREQ, 8'hE0);
        for (i = 0; i < 4; i++) begin
            fire(i[0] ? 2'b10 : 2'b01);
            wait_pin(1'b0);
            wait_pin(1'b1);
        end
        for (i = 1; i < 4; i++) begin
            host.put_ctrl(rcr_pkg::ADDR_ALARM_IRQ_FREQ, {3'h3, 2'(i), 3'h0});
            fire(2'b11);
            falls(n);
            cmp_byte(i == 1 ? 8'h50 : i == 2 ? 8'h0A : 8'h00, i == 3 ? 8'(n / 2) : 8'(n));
        end
        host.put_ctrl(rcr_pkg::ADDR_POWER_SWITCH, 8'hC0);
        on_backup_i = 1'b1;
        repeat (4) @(negedge clk_i);
        cmp_bit(1'b0, bus_enable_o);
        cmp_bit(1'b1, supply_switch_mode_o);
        host.put_ctrl(rcr_pkg::ADDR_CAP_TUNE, ~v[2] & 8'h3F);
        on_backup_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rd_chk(rcr_pkg::ADDR_CAP_TUNE, 8'h3F, v[2]);
        host.put_ctrl(rcr_pkg::ADDR_POWER_SWITCH, 8'h00);
        on_backup_i = 1'b1;
        repeat (4) @(negedge clk_i);
        cmp_bit(1'b1, bus_enable_o);
        cmp_bit(1'b0, supply_switch_mode_o);
        repeat (4) @(negedge clk_i);
        finish_test();
    end
endmodule
bind rcr_ctrl rcr_ctrl_sva chk (.*);
